// ### sptp_ahb_regs.sv
// AHB-Lite slave holding the programmer's control, value and status registers.
`timescale 1ns/1ps
module sptp_ahb_regs
  import sptp_pkg::*;
(
  input wire logic hclk,
  input wire logic hreset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output sptp_cfg_t cfg,
  output sptp_cmd_t cmd,
  input wire sptp_stat_t stat
);

  // ==========================================================================
  // Address phase capture
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  sptp_cfg_t cfg_r;
  sptp_cfg_t cfg_nxt;
  sptp_cmd_t cmd_r;
  sptp_cmd_t cmd_nxt;
  logic take;

  // Every transfer finishes without wait states, so the read word is fetched
  // in the address phase and registered for the data phase.
  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign cfg = cfg_r;
  // Commands are registered in the same cycle as the settings, so a start written together
  // with new mode bits already sees those bits in the settings.
  assign cmd = cmd_r;

  always_comb
  begin
    wr_pend_nxt = take & hwrite & (hsize == 3'h2);
    wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = hrdata_r;
    if (take && !hwrite)
    begin
      hrdata_nxt = 32'h00000000;
      case (haddr[7:0])
        SPTP_CTRL_OFF:
        begin
          hrdata_nxt[CTRL_PERM_BIT] = cfg_r.perm;
          hrdata_nxt[CTRL_LOCK_BIT] = cfg_r.lock;
          hrdata_nxt[CTRL_POWER_BIT] = cfg_r.power;
        end
        SPTP_VALUE_OFF: hrdata_nxt[TRIM_BITS-1:0] = cfg_r.value;
        SPTP_STATUS_OFF:
        begin
          hrdata_nxt[STAT_BUSY_BIT] = stat.busy;
          hrdata_nxt[STAT_DONE_BIT] = stat.done;
          hrdata_nxt[STAT_LOCKED_BIT] = stat.locked;
          hrdata_nxt[STAT_LEVEL_LSB +: 2] = stat.level;
          hrdata_nxt[STAT_STATE_LSB +: 3] = stat.state;
        end
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
    cfg_nxt = cfg_r;
    cmd_nxt = '0;
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        SPTP_CTRL_OFF:
        begin
          cfg_nxt.perm = hwdata[CTRL_PERM_BIT];
          cfg_nxt.lock = hwdata[CTRL_LOCK_BIT];
          cfg_nxt.power = hwdata[CTRL_POWER_BIT];
          cmd_nxt.start = hwdata[CTRL_START_BIT];
          cmd_nxt.clear = hwdata[CTRL_CLEAR_BIT];
        end
        SPTP_VALUE_OFF: cfg_nxt.value = hwdata[TRIM_BITS-1:0];
        SPTP_STATUS_OFF: cmd_nxt.done_clr = hwdata[STAT_DONE_BIT];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge hclk)
  begin
    if (!hreset_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      cfg_r <= '{value: VALUE_RESET, perm: 1'b0, lock: 1'b0, power: POWER_RESET};
      cmd_r <= '0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      cfg_r <= cfg_nxt;
      cmd_r <= cmd_nxt;
    end
  end

endmodule : sptp_ahb_regs

// ### sptp_dev_model.sv
// Behavioural model of the sensor that decodes supply pulses into trim bits.
`timescale 1ns/1ps
module sptp_dev_model
  import sptp_pkg::*;
#(
  parameter int LONG_CYC = 5000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] level,
  output logic [TRIM_BITS-1:0] trim,
  output logic locked
);
  // ==========================================================================
  // Pulse decoder
  // Pulses are judged when they end, so a long high is only known as a fuse afterwards.
  logic [1:0] prev_r, ks_r;
  int dur_r;
  logic [ADDR_W-1:0] cnt_r;
  logic [TRIM_BITS-1:0] prov_r, fuse_r;
  logic hi, lng;
  assign hi = (prev_r == LVL_KEY_FUSE);
  assign lng = (dur_r >= LONG_CYC);
  assign trim = prov_r | fuse_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {prev_r, ks_r, cnt_r, prov_r, fuse_r, locked} <= '0;
      dur_r <= 0;
    end
    else
    begin
      prev_r <= level;
      dur_r <= (level == prev_r) ? dur_r + 1 : 1;
      // A fuse pulse may fall straight to zero, so the pulse is judged before the clear.
      if (level != prev_r && prev_r[1] && !locked)
      begin
        case (ks_r)
          2'h0: ks_r <= (hi && !lng) ? 2'h1 : 2'h0;
          2'h1: ks_r <= hi ? 2'h0 : 2'h2;
          2'h2: ks_r <= (hi && !lng) ? 2'h3 : 2'h0;
          default:
          begin
            if (!hi)
            begin
              cnt_r <= cnt_r + 6'h01;
              prov_r <= TRIM_BITS'(cnt_r + 6'h01);
            end
            else
            begin
              {ks_r, cnt_r} <= '0;
              if (lng && cnt_r == LOCK_ADDR)
                locked <= 1'b1;
              else if (lng && cnt_r != 6'h00 && cnt_r <= 6'h05)
                fuse_r[cnt_r - 6'h01] <= 1'b1;
            end
          end
        endcase
      end
      if (level == LVL_ZERO)
        {ks_r, cnt_r, prov_r} <= '0;
    end
  end
endmodule : sptp_dev_model

// ### sptp_pkg.sv
// Package of constants, level codes and carriers for the supply pulse trim programmer.
package sptp_pkg;

  // ==========================================================================
  // Bus map
  localparam logic [7:0] SPTP_CTRL_OFF = 8'h00;
  localparam logic [7:0] SPTP_VALUE_OFF = 8'h04;
  localparam logic [7:0] SPTP_STATUS_OFF = 8'h08;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PERM_BIT = 1;
  localparam int CTRL_LOCK_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_POWER_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_LOCKED_BIT = 2;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_STATE_LSB = 8;

  localparam logic [4:0] VALUE_RESET = 5'h00;
  localparam logic POWER_RESET = 1'b0;

  // ==========================================================================
  // Trim layout
  localparam int TRIM_BITS = 5;
  localparam int ADDR_W = 6;
  localparam int KEY_PULSES = 3;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 6'h20;
  localparam logic [ADDR_W-1:0] KEY_MID_IDX = 6'h01;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int PULSE_US = 20;
  localparam int GAP_US = 20;
  localparam int FUSE_MIN_US = 100;
  localparam int FUSE_TYP_US = 300;
  localparam int ZERO_US = 100;
  localparam int TMR_W = 20;
  localparam logic [TMR_W-1:0] PULSE_CYC = TMR_W'(PULSE_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] GAP_CYC = TMR_W'(GAP_US * CLK_MHZ);
  localparam int FUSE_CYC_DEF = FUSE_TYP_US * CLK_MHZ;
  localparam int ZERO_CYC_DEF = ZERO_US * CLK_MHZ;

  // ==========================================================================
  // Supply levels driven toward the device
  typedef enum logic [1:0] {
    LVL_ZERO = 2'h0,
    LVL_HOLD = 2'h1,
    LVL_COUNT = 2'h2,
    LVL_KEY_FUSE = 2'h3
  } sptp_level_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_HOLD = 3'h1,
    ST_SETTLE = 3'h2,
    ST_PULSE = 3'h3,
    ST_GAP = 3'h4,
    ST_FUSE = 3'h5,
    ST_ZERO = 3'h6
  } sptp_state_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [TRIM_BITS-1:0] value;
    logic perm;
    logic lock;
    logic power;
  } sptp_cfg_t;

  typedef struct packed {
    logic start;
    logic clear;
    logic done_clr;
  } sptp_cmd_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic locked;
    sptp_level_t level;
    sptp_state_t state;
  } sptp_stat_t;

endpackage : sptp_pkg

// ### sptp_programmer.sv
// Supply pulse programmer that drives the sensor's supply levels to trim its switchpoint.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Trim is five bitfields encoding one of 31 operate steps.
// RULE2: Each mid-level pulse advances the device address counter by one.
// RULE3: Short high pulse separates groups; long high pulse blows the addressed fuse.
// RULE4: Supply at zero clears the device trim and programming state.
// RULE5: Every key or address pulse and every low gap lasts 20 us or more.
// RULE6: Fuse pulse lasts at least 100 us, typically 300 us.
// RULE7: One sequence per set bitfield, with supply brought to zero between sequences.
// RULE8: Trial and permanent sequences match except the final long fuse pulse.
// RULE9: Sequence order is enable key, address pulses, then optional fuse pulse.
// RULE10: Zero between permanent sequences; low level between trial sequences.
// RULE11: A blown bitfield fuse keeps that bitfield at one forever.
// RULE12: Unset bitfields read as zero.
// RULE13: Never blow the fuse of a zero bitfield.
// RULE14: A trial sends the whole value as one address count.
// RULE15: Permanent value splits into one bits; address k weighs two to k minus one.
// RULE16: Addressing opens only after short high, mid, short high key.
// RULE17: Mid pulses after the key count as the target address.
// RULE18: Lock bit is address 32, fused last with the permanent procedure.
// RULE19: After the lock fuse the device ignores all programming.
// RULE20: Release threshold follows operate threshold by a fixed hysteresis.
// RULE21: Before lock, trial trims may be cleared and set again freely.
// RULE22: Device sorts supply into zero, low, mid, high bands and times them.
// RULE23: Device drops a partial key or address on any stray pattern.
module sptp_programmer
  import sptp_pkg::*;
#(
  parameter int FUSE_CYC = FUSE_CYC_DEF,
  parameter int ZERO_CYC = ZERO_CYC_DEF
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic [1:0] SUPPLY_LEVEL,
  output logic BUSY
);

  // ==========================================================================
  // Helpers
  localparam logic [TMR_W-1:0] FUSE_LEN = TMR_W'(FUSE_CYC);
  localparam logic [TMR_W-1:0] ZERO_LEN = TMR_W'(ZERO_CYC);
  localparam logic [TMR_W-1:0] FUSE_FLOOR = TMR_W'(FUSE_MIN_US * CLK_MHZ);
  // A fuse pulse shorter than the floor would leave a bitfield half blown.
  localparam logic [TMR_W-1:0] FUSE_USE = (FUSE_LEN < FUSE_FLOOR) ? FUSE_FLOOR : FUSE_LEN;

  // Address of the lowest one bit still to be fused; address k has weight 2^(k-1).
  function automatic logic [ADDR_W-1:0] low_addr(input logic [TRIM_BITS-1:0] mask);
    logic [ADDR_W-1:0] a;
    a = '0;
    for (int i = TRIM_BITS - 1; i >= 0; i--)
    begin
      if (mask[i])
      begin
        a = ADDR_W'(i + 1);
      end
    end
    return a;
  endfunction : low_addr

  function automatic logic [TRIM_BITS-1:0] drop_addr(input logic [TRIM_BITS-1:0] mask,
                                                     input logic [ADDR_W-1:0] addr);
    logic [TRIM_BITS-1:0] m;
    m = mask;
    for (int i = 0; i < TRIM_BITS; i++)
    begin
      if (ADDR_W'(i + 1) == addr)
      begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction : drop_addr

  // ==========================================================================
  // Register slave
  sptp_cfg_t cfg;
  sptp_cmd_t cmd;
  sptp_stat_t stat;

  sptp_ahb_regs u_regs (
    .hclk(SYS_CLK),
    .hreset_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .hrdata(HRDATA),
    .cfg(cfg),
    .cmd(cmd),
    .stat(stat)
  );

  // ==========================================================================
  // Sequencer state
  sptp_state_t state_r;
  sptp_state_t state_nxt;
  sptp_level_t level_r;
  sptp_level_t level_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic [ADDR_W-1:0] pulse_r;
  logic [ADDR_W-1:0] pulse_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [TRIM_BITS-1:0] left_r;
  logic [TRIM_BITS-1:0] left_nxt;
  logic perm_r;
  logic perm_nxt;
  logic lock_r;
  logic lock_nxt;
  logic done_r;
  logic done_nxt;
  logic locked_r;
  logic locked_nxt;
  logic tmr_end;
  logic idle;
  logic job_end;
  logic [ADDR_W-1:0] pulse_total;

  assign tmr_end = (tmr_r == '0);
  assign idle = (state_r == ST_OFF) || (state_r == ST_HOLD);
  assign pulse_total = ADDR_W'(KEY_PULSES) + addr_r; // RULE9
  assign SUPPLY_LEVEL = level_r;
  assign BUSY = !idle;
  assign stat = '{busy: !idle, done: done_r, locked: locked_r, level: level_r, state: state_r};

  always_comb
  begin
    state_nxt = state_r;
    level_nxt = level_r;
    tmr_nxt = tmr_end ? tmr_r : tmr_r - TMR_W'(1);
    pulse_nxt = pulse_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    perm_nxt = perm_r;
    lock_nxt = lock_r;
    locked_nxt = locked_r;
    job_end = 1'b0;
    case (state_r)
      ST_OFF, ST_HOLD:
      begin
        // Idle supply follows the power bit; low keeps trial bitfields alive.
        level_nxt = cfg.power ? LVL_HOLD : LVL_ZERO; // RULE10
        state_nxt = cfg.power ? ST_HOLD : ST_OFF;
        if (cmd.clear)
        begin
          // Dropping to zero wipes trial trims so a new trial can start.
          level_nxt = LVL_ZERO; // RULE4 RULE21
          tmr_nxt = ZERO_LEN;
          left_nxt = '0;
          perm_nxt = 1'b0;
          state_nxt = ST_ZERO;
        end
        else if (cmd.start)
        begin
          perm_nxt = cfg.perm | cfg.lock; // RULE8
          lock_nxt = cfg.lock;
          pulse_nxt = '0;
          if (cfg.lock)
          begin
            addr_nxt = LOCK_ADDR; // RULE18
            left_nxt = '0;
          end
          else if (cfg.perm)
          begin
            // Only one bits are addressed, so zero bitfields never see a fuse pulse.
            addr_nxt = low_addr(cfg.value); // RULE13 RULE15
            left_nxt = drop_addr(cfg.value, low_addr(cfg.value)); // RULE7
          end
          else
          begin
            addr_nxt = ADDR_W'(cfg.value); // RULE14 RULE1
            left_nxt = '0;
          end
          if (cfg.perm && !cfg.lock && (cfg.value == '0))
          begin
            job_end = 1'b1;
          end
          else
          begin
            level_nxt = LVL_HOLD;
            tmr_nxt = GAP_CYC; // RULE5
            state_nxt = ST_SETTLE;
          end
        end
      end
      ST_SETTLE:
      begin
        if (tmr_end)
        begin
          level_nxt = LVL_KEY_FUSE; // RULE16
          tmr_nxt = PULSE_CYC; // RULE5
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE:
      begin
        if (tmr_end)
        begin
          pulse_nxt = pulse_r + ADDR_W'(1);
          level_nxt = LVL_HOLD;
          tmr_nxt = GAP_CYC; // RULE5
          state_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (tmr_end)
        begin
          if (pulse_r != pulse_total)
          begin
            // Key is high, mid, high; every later pulse is a mid address count.
            level_nxt = (pulse_r == KEY_MID_IDX) || (pulse_r >= ADDR_W'(KEY_PULSES)) ?
                        LVL_COUNT : LVL_KEY_FUSE; // RULE2 RULE16 RULE17
            tmr_nxt = PULSE_CYC;
            state_nxt = ST_PULSE;
          end
          else if (perm_r)
          begin
            level_nxt = LVL_KEY_FUSE; // RULE3 RULE11
            tmr_nxt = FUSE_USE; // RULE6
            state_nxt = ST_FUSE;
          end
          else
          begin
            // Trial finished; supply goes to low and stays there while the power bit is set, so the setting is retained.
            level_nxt = LVL_HOLD; // RULE10 RULE21
            state_nxt = ST_HOLD;
            job_end = 1'b1;
          end
        end
      end
      ST_FUSE:
      begin
        if (tmr_end)
        begin
          level_nxt = LVL_ZERO; // RULE10
          tmr_nxt = ZERO_LEN;
          state_nxt = ST_ZERO;
          if (lock_r)
          begin
            locked_nxt = 1'b1; // RULE19
          end
        end
      end
      ST_ZERO:
      begin
        if (tmr_end)
        begin
          if (left_r != '0)
          begin
            addr_nxt = low_addr(left_r); // RULE15
            left_nxt = drop_addr(left_r, low_addr(left_r));
            pulse_nxt = '0;
            level_nxt = LVL_HOLD;
            tmr_nxt = GAP_CYC;
            state_nxt = ST_SETTLE;
          end
          else
          begin
            level_nxt = cfg.power ? LVL_HOLD : LVL_ZERO;
            state_nxt = cfg.power ? ST_HOLD : ST_OFF;
            job_end = perm_r;
          end
        end
      end
      default:
      begin
        level_nxt = LVL_ZERO;
        state_nxt = ST_OFF;
      end
    endcase
    // A job ending in the same cycle as a clear of the flag still reports done.
    done_nxt = job_end | (done_r & !cmd.done_clr);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      state_r <= ST_OFF;
      level_r <= LVL_ZERO;
      tmr_r <= '0;
      pulse_r <= '0;
      addr_r <= '0;
      left_r <= '0;
      perm_r <= 1'b0;
      lock_r <= 1'b0;
      done_r <= 1'b0;
      locked_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      tmr_r <= tmr_nxt;
      pulse_r <= pulse_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      perm_r <= perm_nxt;
      lock_r <= lock_nxt;
      done_r <= done_nxt;
      locked_r <= locked_nxt;
    end
  end

endmodule : sptp_programmer

// ### sptp_programmer_asserts.sv
// Checker of supply pulse order and timing at the programmer's ports.
`timescale 1ns/1ps
module sptp_programmer_asserts
  import sptp_pkg::*;
#(
  parameter int FUSE_CYC = FUSE_CYC_DEF,
  parameter int ZERO_CYC = ZERO_CYC_DEF
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic [1:0] SUPPLY_LEVEL,
  input wire logic BUSY
);
  // ==========================================================================
  // Helper state
  // The run counter only sees settled levels, so short pulses of any kind are caught.
  localparam int MIN_RUN = 1999;
  localparam int MAX_SHORT = 2100;
  logic [1:0] lvl_r, lvl_nxt, pc_r, pc_nxt;
  int run_r, run_nxt;
  logic busy_r, busy_nxt, dp_r, dp_nxt;
  always_comb
  begin
    lvl_nxt = SUPPLY_LEVEL;
    run_nxt = (SUPPLY_LEVEL == lvl_r) ? run_r + 1 : 0;
    busy_nxt = BUSY;
    dp_nxt = HSEL && HTRANS[1] && HREADY && HWRITE && (HSIZE == 3'h2) && (HADDR[7:0] == 8'h00);
    pc_nxt = pc_r;
    if (!BUSY || SUPPLY_LEVEL == 2'h0)
      pc_nxt = 2'h0;
    else if (pc_r != 2'h3 && lvl_r == 2'h1 && SUPPLY_LEVEL[1])
      pc_nxt = pc_r + 2'h1;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      {lvl_r, pc_r, busy_r, dp_r} <= '0;
      run_r <= 0;
    end
    else
    begin
      {lvl_r, pc_r, busy_r, dp_r} <= {lvl_nxt, pc_nxt, busy_nxt, dp_nxt};
      run_r <= run_nxt;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_pulse_end;
    lvl_r[1] && SUPPLY_LEVEL != lvl_r;
  endsequence
  sequence s_pulse_start;
    lvl_r == 2'h1 && SUPPLY_LEVEL[1];
  endsequence
  property p_rst_idle;
    $rose(RST_N) |-> SUPPLY_LEVEL == 2'h0 && !BUSY;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("supply not zero after reset");
  property p_pulse_min;
    s_pulse_end |-> run_r >= MIN_RUN;
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
  property p_gap_min;
    s_pulse_start |-> run_r >= MIN_RUN;
  endproperty
  a_gap_min: assert property (p_gap_min) else $error("low gap too short");
  property p_mid_short;
    lvl_r == 2'h2 && SUPPLY_LEVEL == 2'h2 |-> run_r < MAX_SHORT;
  endproperty
  a_mid_short: assert property (p_mid_short) else $error("count pulse too long");
  property p_fuse_min;
    lvl_r == 2'h3 && SUPPLY_LEVEL != 2'h3 && run_r >= MAX_SHORT |-> run_r >= FUSE_CYC - 1;
  endproperty
  a_fuse_min: assert property (p_fuse_min) else $error("fuse pulse too short");
  property p_no_jump;
    s_pulse_end |-> !SUPPLY_LEVEL[1];
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("pulse not closed by low");
  property p_key_order;
    s_pulse_start ##0 pc_r != 2'h3 |-> SUPPLY_LEVEL == ((pc_r == 2'h1) ? 2'h2 : 2'h3);
  endproperty
  a_key_order: assert property (p_key_order) else $error("enable key out of order");
  property p_idle_level;
    !BUSY |-> !SUPPLY_LEVEL[1];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("pulse while idle");
  property p_zero_min;
    lvl_r == 2'h0 && SUPPLY_LEVEL != 2'h0 && busy_r |-> run_r >= ZERO_CYC - 1;
  endproperty
  a_zero_min: assert property (p_zero_min) else $error("zero too short");
  property p_start_settle;
    dp_r && HWDATA[0] && HWDATA[3:1] == 3'h0 && !BUSY |-> ##[1:2] (BUSY && SUPPLY_LEVEL == 2'h1);
  endproperty
  a_start_settle: assert property (p_start_settle) else $error("start not taken");
endmodule : sptp_programmer_asserts

bind sptp_programmer sptp_programmer_asserts #(.FUSE_CYC(FUSE_CYC), .ZERO_CYC(ZERO_CYC)) i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .HRDATA(HRDATA), .SUPPLY_LEVEL(SUPPLY_LEVEL), .BUSY(BUSY));

// ### sptp_programmer_test.sv
// Self-checking testbench for the supply pulse trim programmer.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module sptp_programmer_test
  import sptp_pkg::*;
;
  // ==========================================================================
  // Bench state
  // The fuse time sits at the design's floor to keep the run short.
  logic SYS_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, BUSY, dev_locked;
  logic [31:0] HADDR, HWDATA, HRDATA, q, got_d, e;
  logic [1:0] HTRANS, SUPPLY_LEVEL;
  logic [2:0] HSIZE;
  logic [4:0] v, trim;
  logic [31:0] exp_q[$], got_q[$];
  event got_e;
  int error_cnt, cmp_count;
  sptp_programmer #(.FUSE_CYC(10000), .ZERO_CYC(20)) i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .SUPPLY_LEVEL(SUPPLY_LEVEL), .BUSY(BUSY));
  sptp_dev_model i_dev (.clk(SYS_CLK), .rst_n(RST_N), .level(SUPPLY_LEVEL), .trim(trim),
    .locked(dev_locked));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================================================
  // Tasks
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [2:0] sz);
    int n;
    HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= {24'h000000, a}; HWRITE <= wr; HSIZE <= sz;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
    do begin @(posedge SYS_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    q = HRDATA;
    if (n >= 50)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h00000000, 3'h2);
    got_q.push_back(q & m);
    -> got_e;
  endtask : rd
  task automatic see(input logic [31:0] d, input logic [31:0] x);
    exp_q.push_back(x);
    got_q.push_back(d);
    -> got_e;
  endtask : see
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask : wr
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge SYS_CLK);
    while (BUSY !== 1'b0 && n < 70000)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 70000)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_idle
  // ==========================================================================
  // Checker of results against the oldest note
  initial
  begin
    forever
    begin
      @(got_e);
      // Several results may be noted in one time step, so drain them all.
      while (got_q.size() > 0)
      begin
        e = exp_q.pop_front();
        got_d = got_q.pop_front();
        `CHK(got_d, e)
      end
    end
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    {RST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
    error_cnt = 0;
    cmp_count = 0;
    v = 5'($urandom(32'hEEE52283));
    v = 5'($urandom_range(3, 1));
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(SPTP_CTRL_OFF, 32'hFFFFFFFF, 32'h00000000);
    rd(SPTP_STATUS_OFF, 32'hFFFFFFFF, 32'h00000000);
    rd(SPTP_VALUE_OFF, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'hFFFFFFFF, 32'h00000000);
    wr(SPTP_CTRL_OFF, 32'h00000003);
    repeat (3) @(posedge SYS_CLK);
    rd(SPTP_STATUS_OFF, 32'h00000033, 32'h00000002);
    see({30'h0, SUPPLY_LEVEL}, 32'h00000000);
    wr(SPTP_STATUS_OFF, 32'h00000002);
    wr(SPTP_VALUE_OFF, {27'h0, v});
    bus(1'b1, SPTP_VALUE_OFF, 32'h0000001F, 3'h0);
    rd(SPTP_VALUE_OFF, 32'hFFFFFFFF, {27'h0, v});
    wr(SPTP_CTRL_OFF, 32'h00000011);
    repeat (100) @(posedge SYS_CLK);
    wr(SPTP_CTRL_OFF, 32'h00000011);
    wait_idle();
    see({27'h0, trim}, {27'h0, v});
    see({30'h0, SUPPLY_LEVEL}, 32'h00000001);
    rd(SPTP_STATUS_OFF, 32'h00000003, 32'h00000002);
    wr(SPTP_CTRL_OFF, 32'h00000018);
    wait_idle();
    see({27'h0, trim}, 32'h00000000);
    wr(SPTP_VALUE_OFF, 32'h00000005);
    wr(SPTP_CTRL_OFF, 32'h00000003);
    wait_idle();
    see({27'h0, trim}, 32'h00000005);
    see({30'h0, SUPPLY_LEVEL}, 32'h00000000);
    see({30'h0, HRESP, BUSY}, 32'h00000000);
    wr(SPTP_CTRL_OFF, 32'h00000018);
    wait_idle();
    see({27'h0, trim}, 32'h00000005);
    see({31'h0, dev_locked}, 32'h00000000);
    wr(SPTP_CTRL_OFF, 32'h00000014);
    rd(SPTP_CTRL_OFF, 32'hFFFFFFFF, 32'h00000014);
    repeat (2) @(posedge SYS_CLK);
    finish_test();
  end
endmodule : sptp_programmer_test
